// ### core/ascii_mon_pkg.sv
package ascii_mon_pkg;

  // frame characters
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_UP_A = 8'h41;
  localparam logic [7:0] CH_UP_F = 8'h46;
  localparam logic [7:0] CH_LO_A = 8'h61;
  localparam logic [7:0] CH_LO_F = 8'h66;
  localparam logic [7:0] HEX_ALPHA_OFF = 8'h0a;

  // query and response fields
  localparam logic [7:0] FUNC_READ = 8'h03;
  localparam logic [7:0] RESP_NBYTES = 8'h04;
  localparam logic [7:0] SLAVE_BASE = 8'h01;
  localparam logic [15:0] ADDR_DEV = 16'h900e;
  localparam logic [15:0] ADDR_DEV_LO = 16'h900f;
  localparam logic [15:0] ADDR_UPTIME = 16'h9010;
  localparam logic [15:0] ADDR_UPTIME_LO = 16'h9011;
  localparam logic [15:0] READ_COUNT = 16'h0002;
  localparam logic [3:0] QUERY_BYTES = 4'h7;

  // response character positions: ':' + 16 hex + CR + LF
  localparam logic [4:0] RESP_HEX_CHARS = 5'h10;
  localparam logic [4:0] RESP_CR_IDX = 5'h11;
  localparam logic [4:0] RESP_LAST_IDX = 5'h12;

  // millisecond timebase
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0] slave;
    logic [7:0] func;
    logic [15:0] start;
    logic [15:0] count;
    logic [7:0] lrc;
  } query_t;

  typedef struct packed {
    logic [7:0] slave;
    logic [7:0] func;
    logic [7:0] nbytes;
    logic [31:0] data;
    logic [7:0] lrc;
  } resp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RECV = 3'b010,
    ST_SEND = 3'b100
  } state_t;

endpackage

// ### core/uptime_ms_counter.sv
`timescale 1ns/10ps
`default_nettype none

module uptime_ms_counter #(
  parameter int unsigned MS_CYCLES = ascii_mon_pkg::MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  output logic ms_tick_o,
  output logic [31:0] uptime_o
);

  logic [31:0] div;
  wire div_end = div == 32'(MS_CYCLES - 1);

  // only the power-on reset touches these; soft reset is not wired in
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div <= 32'h0;
      ms_tick_o <= 1'b0;
      uptime_o <= 32'h0;
    end else begin
      div <= div_end ? 32'h0 : div + 32'h1;
      ms_tick_o <= div_end;
      if (div_end) begin
        uptime_o <= uptime_o + 32'h1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_uptime_step: assert property (div_end |=> uptime_o == $past(uptime_o) + 32'h1)
    else $error("uptime did not advance on the millisecond");
  a_uptime_hold: assert property (!div_end |=> $stable(uptime_o))
    else $error("uptime changed between milliseconds");

endmodule

`default_nettype wire

// ### core/ascii_monitor_register_reader.sv
// Behaviour
// - The deviation register captures commanded minus feedback position once per 1 ms tick.
// - The deviation is a plain pulse count, passed on without scaling.
// - A read with function 03, start POSITION_DEVIATION_HIGH and count 0002 returns the deviation.
// - A 32-bit counter counts milliseconds since power-on.
// - Soft reset leaves the millisecond counter untouched; only the power-on reset clears it.
// - A read with function 03, start 9010 and count 0002 returns the millisecond counter.
// - The slave address is the axis number plus one, sent as two hex characters.
// - The response carries byte count 04 and eight hex data characters.
// - The high 16-bit word goes out first, then the low word.
// - Frames are ASCII, opened by a colon and closed by CR LF.
// - Query and response carry a two-character check field before the trailer.
`timescale 1ns/10ps
`default_nettype none

module ascii_monitor_register_reader #(
  parameter int unsigned MS_CYCLES = ascii_mon_pkg::MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic soft_rst_i,
  input wire logic [3:0] axis_i,
  input wire logic [31:0] cmd_pos_i,
  input wire logic [31:0] fb_pos_i,
  input wire logic [7:0] rx_char_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  output logic [7:0] tx_char_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i
);

  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= ascii_mon_pkg::CH_0 && c <= ascii_mon_pkg::CH_9) begin
      return {1'b1, c[3:0]};
    end else if (c >= ascii_mon_pkg::CH_UP_A && c <= ascii_mon_pkg::CH_UP_F) begin
      return {1'b1, 4'(c - ascii_mon_pkg::CH_UP_A + ascii_mon_pkg::HEX_ALPHA_OFF)};
    end else if (c >= ascii_mon_pkg::CH_LO_A && c <= ascii_mon_pkg::CH_LO_F) begin
      return {1'b1, 4'(c - ascii_mon_pkg::CH_LO_A + ascii_mon_pkg::HEX_ALPHA_OFF)};
    end
    return 5'h00;
  endfunction

  function automatic logic [7:0] nib_char(input logic [3:0] n);
    if ({4'h0, n} < ascii_mon_pkg::HEX_ALPHA_OFF) begin
      return ascii_mon_pkg::CH_0 + {4'h0, n};
    end
    return ascii_mon_pkg::CH_UP_A + {4'h0, n} - ascii_mon_pkg::HEX_ALPHA_OFF;
  endfunction

  // character i of a response frame
  function automatic logic [7:0] char_at(input logic [4:0] i, input ascii_mon_pkg::resp_t r);
    logic [63:0] v;
    int k;
    v = r;
    k = int'(ascii_mon_pkg::RESP_HEX_CHARS) - int'(i);
    if (i == 5'h00) begin
      return ascii_mon_pkg::CH_COLON;
    end else if (i <= ascii_mon_pkg::RESP_HEX_CHARS) begin
      return nib_char(v[k*4 +: 4]);
    end else if (i == ascii_mon_pkg::RESP_CR_IDX) begin
      return ascii_mon_pkg::CH_CR;
    end
    return ascii_mon_pkg::CH_LF;
  endfunction

  ascii_mon_pkg::state_t state, next_state;
  ascii_mon_pkg::query_t query;
  ascii_mon_pkg::resp_t resp;
  logic [7:0] sum;
  logic [3:0] nbytes;
  logic [3:0] hi_nib;
  logic half;
  logic bad;
  logic cr_seen;
  logic [4:0] idx;
  logic [7:0] tx_char;
  logic [31:0] dev;
  logic [31:0] uptime;
  logic ms_tick;

  uptime_ms_counter #(
    .MS_CYCLES(MS_CYCLES)
  ) u_uptime (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ms_tick_o(ms_tick),
    .uptime_o(uptime)
  );

  // receive side
  wire in_recv = state == ascii_mon_pkg::ST_RECV;
  wire sending = state == ascii_mon_pkg::ST_SEND;
  assign rx_ready_o = !sending;
  wire rx_take = rx_valid_i && rx_ready_o;
  wire is_colon = rx_char_i == ascii_mon_pkg::CH_COLON;
  wire [4:0] hexv = hex_val(rx_char_i);
  wire [7:0] rx_byte = {hi_nib, hexv[3:0]};
  wire body_char = rx_take && in_recv && !is_colon && !cr_seen;
  wire frame_end = rx_take && in_recv && cr_seen && rx_char_i == ascii_mon_pkg::CH_LF;

  // query checks
  wire [7:0] own_slave = {4'h0, axis_i} + ascii_mon_pkg::SLAVE_BASE;
  wire addr_ok = query.slave == own_slave;
  wire lrc_ok = sum == 8'h00;
  wire shape_ok = !bad && !half && nbytes == ascii_mon_pkg::QUERY_BYTES;
  wire is_dev = query.start == ascii_mon_pkg::ADDR_DEV;
  wire is_uptime = query.start == ascii_mon_pkg::ADDR_UPTIME;
  wire cmd_ok = query.func == ascii_mon_pkg::FUNC_READ && query.count == ascii_mon_pkg::READ_COUNT
                && (is_dev || is_uptime);
  wire frame_ok = shape_ok && addr_ok && lrc_ok && cmd_ok;
  wire accept = frame_end && frame_ok;

  // response build
  wire [31:0] sel_value = is_dev ? dev : uptime;
  wire [7:0] body_sum = own_slave + ascii_mon_pkg::FUNC_READ + ascii_mon_pkg::RESP_NBYTES + sel_value[31:24]
                        + sel_value[23:16] + sel_value[15:8] + sel_value[7:0];
  wire ascii_mon_pkg::resp_t next_resp = {own_slave, ascii_mon_pkg::FUNC_READ, ascii_mon_pkg::RESP_NBYTES,
                                          sel_value, 8'h00 - body_sum};
  wire tx_take = tx_valid_o && tx_ready_i;
  wire tx_last = idx == ascii_mon_pkg::RESP_LAST_IDX;
  wire [4:0] idx_inc = idx + 5'h01;
  assign tx_valid_o = sending;
  assign tx_char_o = tx_char;

  always_comb begin
    next_state = state;
    case (state)
      ascii_mon_pkg::ST_IDLE: begin
        if (rx_take && is_colon) begin
          next_state = ascii_mon_pkg::ST_RECV;
        end
      end
      ascii_mon_pkg::ST_RECV: begin
        if (frame_end) begin
          next_state = accept ? ascii_mon_pkg::ST_SEND : ascii_mon_pkg::ST_IDLE;
        end
      end
      ascii_mon_pkg::ST_SEND: begin
        if (tx_take && tx_last) begin
          next_state = ascii_mon_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = ascii_mon_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ascii_mon_pkg::ST_IDLE;
    end else if (soft_rst_i) begin
      state <= ascii_mon_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // a colon always restarts collection
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      query <= '0;
      sum <= 8'h00;
      nbytes <= 4'h0;
      hi_nib <= 4'h0;
      half <= 1'b0;
      bad <= 1'b0;
      cr_seen <= 1'b0;
    end else if (soft_rst_i || (rx_take && is_colon)) begin
      sum <= 8'h00;
      nbytes <= 4'h0;
      half <= 1'b0;
      bad <= 1'b0;
      cr_seen <= 1'b0;
    end else if (body_char) begin
      if (rx_char_i == ascii_mon_pkg::CH_CR) begin
        cr_seen <= 1'b1;
      end else if (!hexv[4]) begin
        bad <= 1'b1;
      end else if (!half) begin
        hi_nib <= hexv[3:0];
        half <= 1'b1;
      end else begin
        half <= 1'b0;
        sum <= sum + rx_byte;
        query <= {query[47:0], rx_byte};
        if (nbytes == ascii_mon_pkg::QUERY_BYTES) begin
          bad <= 1'b1;
        end else begin
          nbytes <= nbytes + 4'h1;
        end
      end
    end else if (rx_take && in_recv && cr_seen && rx_char_i != ascii_mon_pkg::CH_LF) begin
      bad <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      resp <= '0;
      idx <= 5'h00;
      tx_char <= 8'h00;
    end else if (accept) begin
      resp <= next_resp;
      idx <= 5'h00;
      tx_char <= ascii_mon_pkg::CH_COLON;
    end else if (tx_take && !tx_last) begin
      idx <= idx_inc;
      tx_char <= char_at(idx_inc, resp);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dev <= 32'h0;
    end else if (soft_rst_i) begin
      dev <= 32'h0;
    end else if (ms_tick) begin
      dev <= cmd_pos_i - fb_pos_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  wire [7:0] resp_sum = resp.slave + resp.func + resp.nbytes + resp.data[31:24] + resp.data[23:16]
                        + resp.data[15:8] + resp.data[7:0] + resp.lrc;

  a_dev_sample: assert property (ms_tick && !soft_rst_i |=> dev == $past(cmd_pos_i) - $past(fb_pos_i))
    else $error("deviation not captured on the millisecond tick");
  a_dev_read: assert property (accept && is_dev |=> resp.data == $past(dev))
    else $error("deviation read returned wrong value");
  a_uptime_read: assert property (accept && is_uptime |=> resp.data == $past(uptime))
    else $error("uptime read returned wrong value");
  // the counter steps on the same edge that raises ms_tick, so a step is only legal when ms_tick shows it
  a_uptime_soft: assert property (soft_rst_i |=> uptime == $past(uptime) + {31'h0, ms_tick})
    else $error("soft reset disturbed the uptime counter");
  a_slave_echo: assert property ($rose(sending) |-> resp.slave == own_slave)
    else $error("response slave address is not axis plus one");
  a_bytecount_char: assert property (sending && idx == 5'h06 |-> tx_char_o == 8'h34)
    else $error("byte count character is not 4");
  a_high_first: assert property (sending && idx == 5'h07 |-> tx_char_o == nib_char(resp.data[31:28]))
    else $error("high word not sent first");
  a_frame_open: assert property ($rose(sending) |-> tx_char_o == ascii_mon_pkg::CH_COLON)
    else $error("response does not open with a colon");
  // anchored on the CR hand-off so that a stall before the LF does not disturb the check
  a_frame_close: assert property (tx_take && idx == ascii_mon_pkg::RESP_CR_IDX
                                  |-> tx_char_o == ascii_mon_pkg::CH_CR
                                  ##1 (tx_last && tx_char_o == ascii_mon_pkg::CH_LF))
    else $error("response does not close with CR LF");
  a_lrc_zero: assert property (sending |-> resp_sum == 8'h00)
    else $error("response check byte does not balance the sum");
  a_drop_bad: assert property (frame_end && !frame_ok |=> !sending [*2])
    else $error("a rejected query was answered");
  // a soft reset may abort a stalled response
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i && !soft_rst_i |=> tx_valid_o && $stable(tx_char_o))
    else $error("response character changed while stalled");

  c_dev_read: cover property (accept && is_dev ##[1:40] tx_take && tx_last);
  c_uptime_read: cover property (accept && is_uptime ##[1:40] tx_take && tx_last);
  c_bad_lrc: cover property (frame_end && shape_ok && addr_ok && !lrc_ok);
  c_foreign: cover property (frame_end && shape_ok && !addr_ok);

endmodule

`default_nettype wire

// ### tb/serial_master_model.sv
`timescale 1ns/10ps
`default_nettype none

module serial_master_model (
  input wire logic clk_i,
  input wire logic rx_ready_i,
  input wire logic [7:0] tx_char_i,
  input wire logic tx_valid_i,
  output logic [7:0] rx_char_o,
  output logic rx_valid_o,
  output logic tx_ready_o
);
  logic [7:0] resp [0:31];
  int got = 0;
  int stalls = 0;
  logic slow = 1'b0;
  logic lower = 1'b0;

  initial begin
    rx_char_o = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b1;
  end

  function automatic logic [7:0] hexc(input logic [3:0] n, input logic lc);
    if (n < 4'ha) return 8'h30 + {4'h0, n};
    return (lc ? 8'h57 : 8'h37) + {4'h0, n};
  endfunction

  // hold each character until the responder is ready, released line then toggles
  task automatic put(input logic [7:0] c);
    int k = 0;
    rx_char_o = c;
    rx_valid_o = 1'b1;
    @(negedge clk_i);
    while (!rx_ready_i && k < 100) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 100) begin
      stalls++;
    end
    @(posedge clk_i);
    #1;
  endtask

  task automatic send(input logic [7:0] slave, func, input logic [15:0] start, cnt, input logic [7:0] err);
    logic [7:0] b [7];
    b = '{slave, func, start[15:8], start[7:0], cnt[15:8], cnt[7:0], 8'h00};
    b[6] = 8'h00 - (b[0] + b[1] + b[2] + b[3] + b[4] + b[5]) + err;
    got = 0;
    put(8'h3a);
    for (int i = 0; i < 7; i++) begin
      put(hexc(b[i][7:4], lower));
      put(hexc(b[i][3:0], lower));
    end
    put(8'h0d);
    put(8'h0a);
    rx_valid_o = 1'b0;
    rx_char_o = ~rx_char_o;
  endtask

  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o && got < 32) begin
      resp[got] <= tx_char_i;
      got <= got + 1;
    end
    tx_ready_o <= #1 (slow ? ~tx_ready_o : 1'b1);
  end
endmodule

`default_nettype wire

// ### tb/ascii_monitor_register_reader_bench.sv
`timescale 1ns/10ps
`default_nettype none

module ascii_monitor_register_reader_bench;
  localparam int unsigned MSC = 10;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic soft_rst_i = 1'b0;
  logic [3:0] axis_i = 4'h0;
  logic [31:0] cmd_pos_i = 32'h00000100;
  logic [31:0] fb_pos_i = 32'h0000007d;
  logic [7:0] rx_char;
  logic rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0] tx_char;
  logic [31:0] v1, v2, dummy;
  int fail_count = 0;
  int n_tests = 0;

  always #5 clk_i = ~clk_i;

  ascii_monitor_register_reader #(.MS_CYCLES(MSC)) u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .soft_rst_i(soft_rst_i), .axis_i(axis_i),
    .cmd_pos_i(cmd_pos_i), .fb_pos_i(fb_pos_i), .rx_char_i(rx_char), .rx_valid_i(rx_valid),
    .rx_ready_o(rx_ready), .tx_char_o(tx_char), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready)
  );

  serial_master_model u_master (
    .clk_i(clk_i), .rx_ready_i(rx_ready), .tx_char_i(tx_char), .tx_valid_i(tx_valid),
    .rx_char_o(rx_char), .rx_valid_o(rx_valid), .tx_ready_o(tx_ready)
  );

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [3:0] nib(input logic [7:0] c);
    return (c < 8'h41) ? c[3:0] : c[3:0] + 4'h9;
  endfunction

  // one read query; with use_exp low the data field is taken from the reply and the framing checked
  task automatic query(input logic [7:0] slave, func, input logic [15:0] start, cnt, input logic [7:0] err,
                       input logic want, use_exp, input logic [31:0] dexp, output logic [31:0] d);
    logic [7:0] e [19];
    logic [7:0] lrc;
    int k = 0;
    u_master.send(slave, func, start, cnt, err);
    check(rx_ready, !want);
    check(tx_valid, want);
    while (u_master.got < (want ? 19 : 1) && k < 60) begin
      @(posedge clk_i);
      k++;
    end
    #1;
    if (!want) begin
      check(u_master.got, 0);
      return;
    end
    if (k == 60) begin
      fail_count++;
      give_verdict();
    end
    for (int i = 0; i < 8; i++) d[31 - 4 * i -: 4] = nib(u_master.resp[7 + i]);
    if (use_exp) d = dexp;
    lrc = 8'h00 - (slave + 8'h03 + 8'h04 + d[31:24] + d[23:16] + d[15:8] + d[7:0]);
    e = '{8'h3a, u_master.hexc(slave[7:4], 1'b0), u_master.hexc(slave[3:0], 1'b0), 8'h30, 8'h33, 8'h30, 8'h34,
          8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
          u_master.hexc(lrc[7:4], 1'b0), u_master.hexc(lrc[3:0], 1'b0), 8'h0d, 8'h0a};
    for (int i = 0; i < 8; i++) e[7 + i] = u_master.hexc(d[31 - 4 * i -: 4], 1'b0);
    for (int i = 0; i < 19; i++) check(u_master.resp[i], e[i]);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    check(rx_ready, 1'b1);
    check(tx_valid, 1'b0);
    repeat (2 * MSC) @(posedge clk_i);
    #1;
    query(8'h01, 8'h03, 16'h900e, 16'h0002, 8'h00, 1'b1, 1'b1, 32'h00000083, dummy);
    fb_pos_i = 32'h00000105;
    axis_i = 4'hf;
    u_master.lower = 1'b1;
    u_master.slow = 1'b1;
    repeat (2 * MSC) @(posedge clk_i);
    #1;
    query(8'h10, 8'h03, 16'h900e, 16'h0002, 8'h00, 1'b1, 1'b1, 32'hfffffffb, dummy);
    query(8'h10, 8'h03, 16'h9010, 16'h0002, 8'h00, 1'b1, 1'b0, 32'h0, v1);
    soft_rst_i = 1'b1;
    @(posedge clk_i);
    #1;
    soft_rst_i = 1'b0;
    repeat (3 * MSC + 2) @(posedge clk_i);
    #1;
    query(8'h10, 8'h03, 16'h9010, 16'h0002, 8'h00, 1'b1, 1'b0, 32'h0, v2);
    check(v2 >= v1 + 32'h3, 1'b1);
    query(8'h01, 8'h03, 16'h900e, 16'h0002, 8'h00, 1'b0, 1'b0, 32'h0, dummy);
    query(8'h10, 8'h04, 16'h900e, 16'h0002, 8'h00, 1'b0, 1'b0, 32'h0, dummy);
    query(8'h10, 8'h03, 16'h900f, 16'h0002, 8'h00, 1'b0, 1'b0, 32'h0, dummy);
    query(8'h10, 8'h03, 16'h9010, 16'h0001, 8'h00, 1'b0, 1'b0, 32'h0, dummy);
    query(8'h10, 8'h03, 16'h9010, 16'h0002, 8'h01, 1'b0, 1'b0, 32'h0, dummy);
    query(8'h10, 8'h03, 16'h900e, 16'h0002, 8'h00, 1'b1, 1'b1, 32'hfffffffb, dummy);
    check(u_master.stalls, 0);
    give_verdict();
  end
endmodule

`default_nettype wire
